// ===== shared/core_exec_map.vh
// Summary of operation
// - One instruction cycle is four system clocks and all execution steps in whole instruction cycles.
// - Ordinary instructions take one instruction cycle while jump, call, return and table read take two.
// - Writing the low program counter byte, other than by table read, acts as a jump and costs one extra instruction cycle.
// - A conditional skip takes one cycle when nothing is skipped and one more when it skips.
// - A conditional skip tests a data byte or one bit of it and then runs or bypasses the next instruction.
// - A call saves the address after the call and the subroutine exit resumes exactly there.
// - An unconditional jump loads the target address and saves no return address.
// - Bit set and clear change only the addressed bit of an 8-bit location by an internal read-modify-write.
// - And, or, exclusive-or and complement set the zero flag when the result is zero.
// - Rotates move a byte one place left or right and the through-carry forms pass the outgoing bit to carry.
// - Add sets carry above 255 and subtract clears the carry flag on a borrow below 0.
// - Increment and decrement change a data value by exactly one and write it to the chosen destination.
// - Moves exist from register to working register, working register to register, and immediate to working register.
// - Table read instructions read program memory as a constant data table.
// - A halt instruction enters power-down and a separate instruction clears the watchdog timer.
`ifndef CORE_EXEC_MAP_VH
`define CORE_EXEC_MAP_VH

`define CLKS_PER_ICYCLE 4
`define PHASE_SAMPLE    2'h1
`define PHASE_WRITE     2'h2
`define PHASE_LAST      2'h3

`define F_OP_HI   15
`define F_OP_LO   11
`define F_BIT_HI  10
`define F_BIT_LO  8
`define F_DEST    8
`define F_ADDR_HI 10
`define F_ADDR_LO 0
`define F_DATA_HI 7
`define F_DATA_LO 0

`define PC_RESET       11'h000
`define PCL_ADDR       8'h06
`define TBL_PAGE_RESET 3'h7

`define OP_NOP   5'h00
`define OP_MOVAM 5'h01
`define OP_MOVMA 5'h02
`define OP_MOVAI 5'h03
`define OP_ADD   5'h04
`define OP_ADC   5'h05
`define OP_SUB   5'h06
`define OP_SBC   5'h07
`define OP_AND   5'h08
`define OP_OR    5'h09
`define OP_XOR   5'h0a
`define OP_CPL   5'h0b
`define OP_INC   5'h0c
`define OP_DEC   5'h0d
`define OP_RR    5'h0e
`define OP_RL    5'h0f
`define OP_RRC   5'h10
`define OP_RLC   5'h11
`define OP_CLRB  5'h12
`define OP_SETB  5'h13
`define OP_JMP   5'h14
`define OP_CALL  5'h15
`define OP_RET   5'h16
`define OP_INTERRUPT_EXIT  5'h17
`define OP_SZ    5'h18
`define OP_SZB   5'h19
`define OP_SNZB  5'h1a
`define OP_SIZ   5'h1b
`define OP_SDZ   5'h1c
`define OP_TABRD 5'h1d
`define OP_HALT  5'h1e
`define OP_WDTC  5'h1f

`endif

// ===== rtl/phase_gen.v
`timescale 1ns/1ps
`include "core_exec_map.vh"
module phase_gen #(
  parameter DIV = `CLKS_PER_ICYCLE
) (
  input  wire       clk_i,
  input  wire       rstn_i,
  output reg  [1:0] phase_o
);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_o <= 2'h0;
    end else if (phase_o == DIV - 1) begin
      phase_o <= 2'h0;
    end else begin
      phase_o <= phase_o + 2'h1;
    end
  end
endmodule // phase_gen

// ===== rtl/core_exec.v
`timescale 1ns/1ps
`include "core_exec_map.vh"
module core_exec #(
  parameter PC_W        = 11,
  parameter STACK_DEPTH = 8,
  parameter SP_W        = 3
) (
  input  wire            CLK_SYS_I,
  input  wire            RSTN_I,
  input  wire [15:0]     PM_DATA_I,
  input  wire [7:0]      DM_RDATA_I,
  input  wire            WAKE_I,
  output wire [PC_W-1:0] PM_ADDR_O,
  output wire [7:0]      DM_ADDR_O,
  output reg  [7:0]      DM_WDATA_O,
  output reg             DM_WE_O,
  output reg  [7:0]      ACC_O,
  output reg             ZERO_O,
  output reg             CARRY_O,
  output reg  [7:0]      TBL_HIGH_O,
  output reg             HALT_O,
  output reg             WDT_CLR_O,
  output wire [1:0]      PHASE_O
);
  reg  [PC_W-1:0] pc_reg;
  reg  [15:0]     ir_reg;
  reg             ir_valid_reg;
  reg             tbl_stall_reg;
  reg  [7:0]      operand_reg;
  reg  [2:0]      wake_sync_reg;
  reg             wake_reg;
  reg  [7:0]      tbl_dst_reg;
  reg  [SP_W-1:0] sp_reg;
  reg  [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
  wire [1:0]      phase;
  wire [4:0]      op     = ir_reg[`F_OP_HI:`F_OP_LO];
  wire [2:0]      bit_no = ir_reg[`F_BIT_HI:`F_BIT_LO];
  wire            dest_m = ir_reg[`F_DEST];
  wire [7:0]      imm    = ir_reg[`F_DATA_HI:`F_DATA_LO];
  wire            exec   = ir_valid_reg && !tbl_stall_reg && !HALT_O;
  wire [PC_W-1:0] tbl_addr = {`TBL_PAGE_RESET, ACC_O};

  reg  [7:0]      res;
  reg             res_c;
  reg             wr_mem;
  reg             wr_acc;
  reg             upd_z;
  reg             upd_c;
  reg             skip;
  reg  [8:0]      sum;
  reg  [7:0]      mask;

  phase_gen #(
    .DIV(`CLKS_PER_ICYCLE)
  ) u_phase (
    .clk_i  (CLK_SYS_I),
    .rstn_i (RSTN_I),
    .phase_o(phase)
  );

  assign PHASE_O   = phase;
  // The next word is already in the instruction register during the table cycle.
  assign DM_ADDR_O = tbl_stall_reg ? tbl_dst_reg : imm;
  // The table fetch borrows the program bus for one cycle, so prefetch pauses then.
  assign PM_ADDR_O = tbl_stall_reg ? tbl_addr : pc_reg;

  always @* begin
    res    = operand_reg;
    res_c  = CARRY_O;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    skip   = 1'b0;
    sum    = 9'h000;
    mask   = 8'h01 << bit_no;
    case (op)
      `OP_MOVAM: begin
        wr_acc = 1'b1;
      end
      `OP_MOVMA: begin
        res    = ACC_O;
        wr_mem = 1'b1;
      end
      `OP_MOVAI: begin
        res    = imm;
        wr_acc = 1'b1;
      end
      `OP_ADD, `OP_ADC: begin
        sum    = {1'b0, ACC_O} + {1'b0, operand_reg} + {8'h00, (op == `OP_ADC) & CARRY_O};
        res    = sum[7:0];
        res_c  = sum[8];
        wr_acc = !dest_m;
        wr_mem = dest_m;
        upd_z  = 1'b1;
        upd_c  = 1'b1;
      end
      `OP_SUB, `OP_SBC: begin
        sum    = {1'b0, ACC_O} - {1'b0, operand_reg} - {8'h00, (op == `OP_SBC) & !CARRY_O};
        res    = sum[7:0];
        res_c  = !sum[8];
        wr_acc = !dest_m;
        wr_mem = dest_m;
        upd_z  = 1'b1;
        upd_c  = 1'b1;
      end
      `OP_AND, `OP_OR, `OP_XOR, `OP_CPL: begin
        case (op)
          `OP_AND: res = ACC_O & operand_reg;
          `OP_OR:  res = ACC_O | operand_reg;
          `OP_XOR: res = ACC_O ^ operand_reg;
          default: res = ~operand_reg;
        endcase
        wr_acc = !dest_m;
        wr_mem = dest_m;
        upd_z  = 1'b1;
      end
      `OP_INC, `OP_DEC: begin
        res    = (op == `OP_INC) ? operand_reg + 8'h01 : operand_reg - 8'h01;
        wr_acc = !dest_m;
        wr_mem = dest_m;
        upd_z  = 1'b1;
      end
      `OP_RR, `OP_RL, `OP_RRC, `OP_RLC: begin
        case (op)
          `OP_RR:  res = {operand_reg[0], operand_reg[7:1]};
          `OP_RL:  res = {operand_reg[6:0], operand_reg[7]};
          `OP_RRC: res = {CARRY_O, operand_reg[7:1]};
          default: res = {operand_reg[6:0], CARRY_O};
        endcase
        res_c  = (op == `OP_RRC) ? operand_reg[0] : operand_reg[7];
        upd_c  = (op == `OP_RRC) || (op == `OP_RLC);
        wr_acc = !dest_m;
        wr_mem = dest_m;
      end
      `OP_CLRB: begin
        res    = operand_reg & ~mask;
        wr_mem = 1'b1;
      end
      `OP_SETB: begin
        res    = operand_reg | mask;
        wr_mem = 1'b1;
      end
      `OP_SZ: begin
        skip   = (operand_reg == 8'h00);
        wr_acc = dest_m;
      end
      `OP_SZB: begin
        skip = ((operand_reg & mask) == 8'h00);
      end
      `OP_SNZB: begin
        skip = ((operand_reg & mask) != 8'h00);
      end
      `OP_SIZ, `OP_SDZ: begin
        res    = (op == `OP_SIZ) ? operand_reg + 8'h01 : operand_reg - 8'h01;
        skip   = (res == 8'h00);
        wr_acc = dest_m;
        wr_mem = !dest_m;
      end
      `OP_RET, `OP_INTERRUPT_EXIT: begin
        res    = imm;
        wr_acc = dest_m;
      end
      default: begin
        res = operand_reg;
      end
    endcase
  end

  wire pcl_hit = wr_mem && (imm == `PCL_ADDR);

  // Data memory strobes: write data is set up one phase early so the store lands at cycle end.
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      operand_reg <= 8'h00;
      DM_WDATA_O  <= 8'h00;
      DM_WE_O     <= 1'b0;
      TBL_HIGH_O  <= 8'h00;
      tbl_dst_reg <= 8'h00;
    end else begin
      DM_WE_O <= 1'b0;
      if ((phase == `PHASE_LAST) && exec && (op == `OP_TABRD)) begin
        tbl_dst_reg <= imm;
      end
      if (phase == `PHASE_SAMPLE) begin
        operand_reg <= tbl_stall_reg ? PM_DATA_I[7:0] : DM_RDATA_I;
        if (tbl_stall_reg) begin
          TBL_HIGH_O <= PM_DATA_I[15:8];
        end
      end
      if (phase == `PHASE_WRITE) begin
        if (tbl_stall_reg && !HALT_O) begin
          DM_WDATA_O <= operand_reg;
          DM_WE_O    <= 1'b1;
        end else if (exec && wr_mem && !pcl_hit) begin
          DM_WDATA_O <= res;
          DM_WE_O    <= 1'b1;
        end
      end
    end
  end

  // Wake is a pin, so it passes three stages and counts once the last two agree.
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wake_sync_reg <= 3'h0;
      wake_reg      <= 1'b0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[1:0], WAKE_I};
      if (wake_sync_reg[2] == wake_sync_reg[1]) begin
        wake_reg <= wake_sync_reg[2];
      end
    end
  end
  wire wake = wake_reg;

  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pc_reg        <= `PC_RESET;
      ir_reg        <= 16'h0000;
      ir_valid_reg  <= 1'b0;
      tbl_stall_reg <= 1'b0;
      ACC_O         <= 8'h00;
      ZERO_O        <= 1'b0;
      CARRY_O       <= 1'b0;
      HALT_O        <= 1'b0;
      WDT_CLR_O     <= 1'b0;
      sp_reg        <= {SP_W{1'b0}};
    end else begin
      WDT_CLR_O <= 1'b0;
      if (HALT_O) begin
        if (wake) begin
          HALT_O <= 1'b0;
        end
      end else if (phase == `PHASE_LAST) begin
        if (tbl_stall_reg) begin
          tbl_stall_reg <= 1'b0;
        end else begin
          ir_reg       <= PM_DATA_I;
          ir_valid_reg <= 1'b1;
          pc_reg       <= pc_reg + 1'b1;
          if (exec) begin
            if (wr_acc) begin
              ACC_O <= res;
            end
            if (upd_z) begin
              ZERO_O <= (res == 8'h00);
            end
            if (upd_c) begin
              CARRY_O <= res_c;
            end
            case (op)
              `OP_JMP: begin
                pc_reg       <= ir_reg[`F_ADDR_HI:`F_ADDR_LO];
                ir_valid_reg <= 1'b0;
              end
              `OP_CALL: begin
                stack_mem[sp_reg] <= pc_reg;
                sp_reg            <= sp_reg + 1'b1;
                pc_reg            <= ir_reg[`F_ADDR_HI:`F_ADDR_LO];
                ir_valid_reg      <= 1'b0;
              end
              `OP_RET, `OP_INTERRUPT_EXIT: begin
                pc_reg       <= stack_mem[sp_reg - 1'b1];
                sp_reg       <= sp_reg - 1'b1;
                ir_valid_reg <= 1'b0;
              end
              `OP_TABRD: begin
                tbl_stall_reg <= 1'b1;
              end
              `OP_HALT: begin
                HALT_O <= 1'b1;
              end
              `OP_WDTC: begin
                WDT_CLR_O <= 1'b1;
              end
              default: begin
                if (pcl_hit) begin
                  pc_reg       <= {pc_reg[PC_W-1:8], res};
                  ir_valid_reg <= 1'b0;
                end else if (skip) begin
                  ir_valid_reg <= 1'b0;
                end
              end
            endcase
          end
        end
      end
    end
  end
endmodule // core_exec

// ===== verification/core_exec_props.sv
`timescale 1ns/1ps
module core_exec_props #(
  parameter PC_W = 11
) (
  input            CLK_SYS_I,
  input            RSTN_I,
  input [15:0]     PM_DATA_I,
  input [7:0]      DM_RDATA_I,
  input            WAKE_I,
  input [PC_W-1:0] PM_ADDR_O,
  input [7:0]      DM_ADDR_O,
  input [7:0]      DM_WDATA_O,
  input            DM_WE_O,
  input [7:0]      ACC_O,
  input            ZERO_O,
  input            CARRY_O,
  input [7:0]      TBL_HIGH_O,
  input            HALT_O,
  input            WDT_CLR_O,
  input [1:0]      PHASE_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RSTN_I);
  phase_wrap_a: assert property (PHASE_O == 2'h3 |=> PHASE_O == 2'h0)
    else $error("phase did not wrap");
  phase_step_a: assert property (PHASE_O == 2'h1 |=> PHASE_O == 2'h2 ##1 PHASE_O == 2'h3)
    else $error("phase did not advance");
  write_phase_a: assert property (DM_WE_O |-> PHASE_O == 2'h3)
    else $error("write outside last phase");
  write_pulse_a: assert property (DM_WE_O |=> !DM_WE_O)
    else $error("write strobe too long");
  pcl_write_a: assert property (DM_WE_O |-> DM_ADDR_O != 8'h06)
    else $error("low counter stored as data");
  wdt_pulse_a: assert property (WDT_CLR_O |=> !WDT_CLR_O)
    else $error("watchdog clear too long");
  halt_quiet_a: assert property (HALT_O |-> !DM_WE_O)
    else $error("write while halted");
  halt_hold_a: assert property ((HALT_O && !WAKE_I) [*5] |=> HALT_O)
    else $error("halt left without wake");
  state_hold_a: assert property (PHASE_O != 2'h3 |=> $stable(ACC_O) && $stable(CARRY_O))
    else $error("state changed mid cycle");
  cover property (DM_WE_O);
  cover property ($fell(HALT_O));
  cover property ($changed(TBL_HIGH_O));
endmodule // core_exec_props
bind core_exec core_exec_props #(.PC_W(PC_W)) u_props (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .PM_DATA_I(PM_DATA_I), .DM_RDATA_I(DM_RDATA_I),
  .WAKE_I(WAKE_I), .PM_ADDR_O(PM_ADDR_O), .DM_ADDR_O(DM_ADDR_O), .DM_WDATA_O(DM_WDATA_O),
  .DM_WE_O(DM_WE_O), .ACC_O(ACC_O), .ZERO_O(ZERO_O), .CARRY_O(CARRY_O),
  .TBL_HIGH_O(TBL_HIGH_O), .HALT_O(HALT_O), .WDT_CLR_O(WDT_CLR_O), .PHASE_O(PHASE_O)
);

// ===== verification/mcu_instruction_exec_timing_tb.sv
`timescale 1ns/1ps
`include "core_exec_map.vh"
module mcu_instruction_exec_timing_tb;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         wake = 1'b0;
  reg  [15:0] rom [0:2047];
  reg  [7:0]  dm [0:255];
  wire [10:0] pm_a;
  wire [7:0]  dm_a;
  wire [7:0]  wd;
  wire [7:0]  acc;
  wire [7:0]  tbh;
  wire [1:0]  ph;
  wire        we;
  wire        zero;
  wire        carry;
  wire        halt;
  wire        wdt;
  integer     wdt_cnt = 0;
  integer     miscompares = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     i;
  integer     n;
  initial forever #25 clk = ~clk;
  core_exec u_dut (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .PM_DATA_I(rom[pm_a]), .DM_RDATA_I(dm[dm_a]),
    .WAKE_I(wake), .PM_ADDR_O(pm_a), .DM_ADDR_O(dm_a), .DM_WDATA_O(wd), .DM_WE_O(we),
    .ACC_O(acc), .ZERO_O(zero), .CARRY_O(carry), .TBL_HIGH_O(tbh), .HALT_O(halt),
    .WDT_CLR_O(wdt), .PHASE_O(ph)
  );
  // Data memory stores on the edge that ends the last phase, while the strobe is high.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (we) dm[dm_a] <= wd;
    if (wdt) wdt_cnt <= wdt_cnt + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  function [15:0] w(input [4:0] op, input [2:0] b, input [7:0] a);
    w = {op, b, a};
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task boot;
    begin
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 2048; i = i + 1) rom[i] = 16'h0000;
      for (i = 0; i < 256; i = i + 1) dm[i] = 8'h00;
    end
  endtask
  task step(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  // Sampling one ns after the edge keeps the checks clear of the edge's own updates.
  task run(input integer k);
    begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      step(k);
    end
  endtask
  task s_alu;
    begin
      boot;
      rom[0] = w(`OP_MOVAI, 3'h0, 8'hf0);
      rom[1] = w(`OP_ADD, 3'h0, 8'h10);
      rom[2] = w(`OP_MOVMA, 3'h1, 8'h11);
      rom[3] = w(`OP_SUB, 3'h0, 8'h10);
      rom[4] = w(`OP_XOR, 3'h0, 8'h12);
      rom[5] = w(`OP_JMP, 3'h0, 8'h05);
      dm[8'h10] = 8'h20;
      dm[8'h12] = 8'hf0;
      run(18);
      check(acc, 8'h10);
      check({7'h00, carry}, 8'h01);
      step(20);
      check(dm[8'h11], 8'h10);
      check({7'h00, carry}, 8'h00);
      check(acc, 8'h00);
      check({7'h00, zero}, 8'h01);
    end
  endtask
  task s_bits;
    begin
      boot;
      rom[0] = w(`OP_MOVAI, 3'h0, 8'h03);
      rom[1] = w(`OP_TABRD, 3'h0, 8'h17);
      rom[2] = w(`OP_SETB, 3'h7, 8'h12);
      rom[3] = w(`OP_CLRB, 3'h0, 8'h12);
      rom[4] = w(`OP_RLC, 3'h1, 8'h12);
      rom[5] = w(`OP_INC, 3'h1, 8'h13);
      rom[6] = w(`OP_DEC, 3'h0, 8'h14);
      rom[7] = w(`OP_JMP, 3'h0, 8'h07);
      rom[11'h703] = 16'ha55a;
      dm[8'h12] = 8'h01;
      dm[8'h13] = 8'hff;
      dm[8'h14] = 8'h05;
      run(60);
      check(dm[8'h17], 8'h5a);
      check(tbh, 8'ha5);
      check(dm[8'h12], 8'h00);
      check({7'h00, carry}, 8'h01);
      check(dm[8'h13], 8'h00);
      check(acc, 8'h04);
    end
  endtask
  // Call, taken skip and return each cost a dead cycle, so the write lands in cycle 8.
  task s_flow;
    begin
      boot;
      rom[0] = w(`OP_CALL, 3'h0, 8'h08);
      rom[1] = w(`OP_MOVMA, 3'h1, 8'h20);
      rom[2] = w(`OP_JMP, 3'h0, 8'h02);
      rom[8] = w(`OP_MOVAI, 3'h0, 8'h11);
      rom[9] = w(`OP_SZ, 3'h0, 8'h15);
      rom[10] = w(`OP_MOVAI, 3'h0, 8'hee);
      rom[11] = w(`OP_RET, 3'h0, 8'h00);
      run(0);
      n = 0;
      for (i = 0; i < 100 && we !== 1'b1; i = i + 1) begin
        if (ph === 2'h3) n = n + 1;
        step(1);
      end
      check(n[7:0], 8'h08);
      step(20);
      check(dm[8'h20], 8'h11);
      check(acc, 8'h11);
    end
  endtask
  task s_halt;
    begin
      boot;
      rom[0] = w(`OP_WDTC, 3'h0, 8'h00);
      rom[1] = w(`OP_HALT, 3'h0, 8'h00);
      rom[2] = w(`OP_MOVAI, 3'h0, 8'h77);
      rom[3] = w(`OP_JMP, 3'h0, 8'h03);
      run(40);
      check({7'h00, halt}, 8'h01);
      check(acc, 8'h00);
      check(wdt_cnt[7:0], 8'h01);
      @(posedge clk);
      wake <= 1'b1;
      repeat (4) @(posedge clk);
      wake <= 1'b0;
      step(40);
      check({7'h00, halt}, 8'h00);
      check(acc, 8'h77);
    end
  endtask
  task s_more;
    begin
      boot;
      rom[0] = w(`OP_MOVAM, 3'h0, 8'h30);
      rom[1] = w(`OP_AND, 3'h0, 8'h31);
      rom[2] = w(`OP_OR, 3'h1, 8'h32);
      rom[3] = w(`OP_CPL, 3'h0, 8'h33);
      rom[4] = w(`OP_MOVAI, 3'h0, 8'h07);
      rom[5] = w(`OP_MOVMA, 3'h0, 8'h06);
      rom[6] = w(`OP_MOVAI, 3'h0, 8'hee);
      rom[7] = w(`OP_SNZB, 3'h1, 8'h34);
      rom[8] = w(`OP_MOVAI, 3'h0, 8'hee);
      rom[9] = w(`OP_SIZ, 3'h0, 8'h35);
      rom[10] = w(`OP_MOVAI, 3'h0, 8'hee);
      rom[11] = w(`OP_JMP, 3'h0, 8'h0b);
      dm[8'h30] = 8'h0f;
      dm[8'h31] = 8'h3c;
      dm[8'h32] = 8'h30;
      dm[8'h33] = 8'hff;
      dm[8'h34] = 8'h02;
      dm[8'h35] = 8'hff;
      run(70);
      check(dm[8'h32], 8'h3c);
      check({7'h00, zero}, 8'h01);
      check(dm[8'h06], 8'h00);
      check(acc, 8'h07);
      check(dm[8'h35], 8'h00);
    end
  endtask
  task finish_test;
    begin
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    s_alu;
    s_bits;
    s_flow;
    s_more;
    s_halt;
    finish_test;
  end
endmodule // mcu_instruction_exec_timing_tb
